/* File: verilog/hbc_pkg.sv */
// ==========================================================================
// Shared constants and types
package hbc_pkg;

    // ======================================================================
    // Bus layout
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RATE = 8'h04;
    localparam logic [7:0] OFS_IRQ_EN = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ======================================================================
    // Control register fields
    localparam int CTRL_W = 5;
    localparam int CTRL_RETENTION_BIT = 1;
    localparam int CTRL_BUSY_BIT = 8;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [31:0] RATE_RESET = 32'h0000_0000;

    typedef struct packed {
        logic status_view_select;
        logic battery_low_detect_enable;
        logic write_bus_stall_enable;
        logic retention_enable;
        logic unit_enable;
    } hbc_ctrl_type;

    // ======================================================================
    // Interrupt source positions
    localparam int IRQ_N = 7;
    localparam int WR_COMPLETE_IRQ = 0;
    localparam int WAKE_PIN_IRQ = 1;
    localparam int BATTERY_LOW_IRQ = 2;
    localparam int COUNTER_MATCH_IRQ = 3;
    localparam int SUPPLY_FAIL_IRQ = 4;
    localparam int RESET_WAKE_IRQ = 5;
    localparam int GPIO_WAKE_IRQ = 6;
    localparam logic [6:0] IRQ_RESET = 7'h00;

    // ======================================================================
    // Write completion time
    localparam int CLK_PERIOD_NS = 10;
    localparam int WR_TIME_NS = 40;
    localparam int WR_CYCLES_INT = (WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] WR_CYCLES = WR_CYCLES_INT[3:0];

    // ======================================================================
    // Write channel states
    typedef enum logic [2:0] {
        WST_IDLE = 3'b001,
        WST_BUSY = 3'b010,
        WST_RESP = 3'b100
    } hbc_wstate_type;

endpackage

/* File: verilog/hbc_pin_hold.sv */
// ==========================================================================
// Pin level hold stage
module hbc_pin_hold #(
    parameter int PINS = 8
) (
    input wire logic clk,
    input wire logic bat_rst_n,
    input wire logic hold,
    input wire logic [PINS-1:0] gpio_out,
    output logic [PINS-1:0] pad_out
);

    // ======================================================================
    // One flop per pin, frozen while holding
    for (genvar p = 0; p < PINS; p++)
    begin : g_pin
        always_ff @(posedge clk or negedge bat_rst_n)
        begin
            if (!bat_rst_n)
            begin
                pad_out[p] <= 1'b0;
            end
            else if (!hold)
            begin
                pad_out[p] <= gpio_out[p];
            end
        end
    end

endmodule

/* File: verilog/hbc_ctrl.sv */
// ==========================================================================
// Hibernation control, interrupts and pin retention
// Behaviour
// - Disabled unit offers no wake, interrupt or retention function.
// - With retention on, pin levels are held through hibernation and after wake.
// - Entering hibernation resets the GPIO unit; only retention keeps levels.
// - Turning retention off releases held pins back to the GPIO unit.
// - Retention setting reads back as a single bit.
// - Seven interrupt sources, each with its own enable bit.
// - A pending source stays asserted until software clears it.
// - Any combination of sources clears in one write, enable layout.
// - Any combination of sources is disabled by the enable mask.
// - Raw or masked status view, selected for reads, enable layout.
// - Active bit survives processor reset, telling wake from cold start.
// - An already active unit needs no re-enable; status reads at once.
// - Raw status keeps the wake cause across processor reset.
// - Detected low battery sets the low-battery raw status bit.
//
// Chosen here: the address map and the AXI4-Lite slave port.
module hbc_ctrl #(
    parameter int PINS = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic vbat_rst_b,
    input wire logic [hbc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [hbc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [hbc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [hbc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wake_pin_evt,
    input wire logic battery_low,
    input wire logic counter_match_evt,
    input wire logic supply_fail,
    input wire logic reset_wake_evt,
    input wire logic gpio_wake_evt,
    input wire logic hib_req,
    input wire logic [PINS-1:0] gpio_out,
    output logic [PINS-1:0] pad_out,
    output logic gpio_unit_rst,
    output logic irq
);

    // ======================================================================
    // Reset release
    logic [1:0] sys_sync;
    logic [1:0] bat_sync;
    logic rst_n;
    logic bat_rst_n;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sys_sync <= 2'b00;
        end
        else
        begin
            sys_sync <= {sys_sync[0], 1'b1};
        end
    end

    always_ff @(posedge clk or negedge vbat_rst_b)
    begin
        if (!vbat_rst_b)
        begin
            bat_sync <= 2'b00;
        end
        else
        begin
            bat_sync <= {bat_sync[0], 1'b1};
        end
    end

    assign rst_n = sys_sync[1];
    assign bat_rst_n = bat_sync[1];

    // ======================================================================
    // Declarations
    hbc_pkg::hbc_ctrl_type ctrl;
    hbc_pkg::hbc_wstate_type wstate;
    logic [7:0] rate_byte [4];
    logic [hbc_pkg::IRQ_N-1:0] irq_en;
    logic [hbc_pkg::IRQ_N-1:0] raw;
    logic [hbc_pkg::IRQ_N-1:0] masked;
    logic [hbc_pkg::IRQ_N-1:0] evt;
    logic [hbc_pkg::IRQ_N-1:0] clr;
    logic [hbc_pkg::ADDR_W-1:0] aw_addr;
    logic [hbc_pkg::DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic aw_full;
    logic w_full;
    logic wr_fire;
    logic sel_ctrl;
    logic sel_rate;
    logic sel_en;
    logic sel_clr;
    logic sel_hit;
    logic [3:0] wr_cnt;
    logic wr_done;
    logic busy;
    logic hold_active;
    logic [hbc_pkg::DATA_W-1:0] next_rdata;
    logic next_rhit;
    logic rd_ctrl_q;

    // ======================================================================
    // Write address and data capture, either order
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_full <= 1'b0;
            aw_addr <= '0;
            s_axi_awready <= 1'b1;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            aw_full <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_full <= 1'b0;
            w_data <= '0;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b1;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            w_full <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    assign wr_fire = (wstate == hbc_pkg::WST_IDLE) && aw_full && w_full;

    // ======================================================================
    // Write decode
    always_comb
    begin
        sel_ctrl = 1'b0;
        sel_rate = 1'b0;
        sel_en = 1'b0;
        sel_clr = 1'b0;
        if (aw_addr[7:2] == hbc_pkg::OFS_CTRL[7:2])
        begin
            sel_ctrl = 1'b1;
        end
        else if (aw_addr[7:2] == hbc_pkg::OFS_RATE[7:2])
        begin
            sel_rate = 1'b1;
        end
        else if (aw_addr[7:2] == hbc_pkg::OFS_IRQ_EN[7:2])
        begin
            sel_en = 1'b1;
        end
        else if (aw_addr[7:2] == hbc_pkg::OFS_IRQ_CLEAR[7:2])
        begin
            sel_clr = 1'b1;
        end
        sel_hit = sel_ctrl || sel_rate || sel_en || sel_clr
            || (aw_addr[7:2] == hbc_pkg::OFS_IRQ_STATUS[7:2]);
    end

    // ======================================================================
    // Write response, optionally stalled until write complete
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wstate <= hbc_pkg::WST_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= hbc_pkg::RESP_OKAY;
        end
        else
        begin
            case (wstate)
                hbc_pkg::WST_IDLE:
                begin
                    if (wr_fire)
                    begin
                        s_axi_bresp <= sel_hit ? hbc_pkg::RESP_OKAY : hbc_pkg::RESP_SLVERR;
                        if (ctrl.write_bus_stall_enable)
                        begin
                            wstate <= hbc_pkg::WST_BUSY;
                        end
                        else
                        begin
                            wstate <= hbc_pkg::WST_RESP;
                            s_axi_bvalid <= 1'b1;
                        end
                    end
                end
                hbc_pkg::WST_BUSY:
                begin
                    if (wr_done)
                    begin
                        wstate <= hbc_pkg::WST_RESP;
                        s_axi_bvalid <= 1'b1;
                    end
                end
                hbc_pkg::WST_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        wstate <= hbc_pkg::WST_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default:
                begin
                    wstate <= hbc_pkg::WST_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // ======================================================================
    // Write completion timer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_cnt <= 4'h0;
        end
        else if (wr_fire)
        begin
            wr_cnt <= hbc_pkg::WR_CYCLES;
        end
        else if (wr_cnt != 4'h0)
        begin
            wr_cnt <= wr_cnt - 4'h1;
        end
    end

    assign wr_done = (wr_cnt == 4'h1);
    assign busy = (wr_cnt != 4'h0);

    // ======================================================================
    // Battery-backed settings
    always_ff @(posedge clk or negedge bat_rst_n)
    begin
        if (!bat_rst_n)
        begin
            ctrl <= hbc_pkg::hbc_ctrl_type'(hbc_pkg::CTRL_RESET);
        end
        else if (wr_fire && sel_ctrl && w_strb[0])
        begin
            ctrl <= hbc_pkg::hbc_ctrl_type'(w_data[hbc_pkg::CTRL_W-1:0]);
        end
    end

    for (genvar b = 0; b < 4; b++)
    begin : g_rate
        always_ff @(posedge clk or negedge bat_rst_n)
        begin
            if (!bat_rst_n)
            begin
                rate_byte[b] <= hbc_pkg::RATE_RESET[8*b +: 8];
            end
            else if (wr_fire && sel_rate && w_strb[b])
            begin
                rate_byte[b] <= w_data[8*b +: 8];
            end
        end
    end

    always_ff @(posedge clk or negedge bat_rst_n)
    begin
        if (!bat_rst_n)
        begin
            irq_en <= hbc_pkg::IRQ_RESET;
        end
        else if (wr_fire && sel_en && w_strb[0])
        begin
            irq_en <= w_data[hbc_pkg::IRQ_N-1:0];
        end
    end

    // ======================================================================
    // Interrupt sources and raw status
    always_comb
    begin
        evt = '0;
        evt[hbc_pkg::WR_COMPLETE_IRQ] = wr_done;
        evt[hbc_pkg::WAKE_PIN_IRQ] = wake_pin_evt;
        evt[hbc_pkg::BATTERY_LOW_IRQ] = battery_low && ctrl.battery_low_detect_enable;
        evt[hbc_pkg::COUNTER_MATCH_IRQ] = counter_match_evt;
        evt[hbc_pkg::SUPPLY_FAIL_IRQ] = supply_fail;
        evt[hbc_pkg::RESET_WAKE_IRQ] = reset_wake_evt;
        evt[hbc_pkg::GPIO_WAKE_IRQ] = gpio_wake_evt;
        if (!ctrl.unit_enable)
        begin
            evt = '0;
        end
    end

    assign clr = (wr_fire && sel_clr && w_strb[0]) ? w_data[hbc_pkg::IRQ_N-1:0] : '0;

    always_ff @(posedge clk or negedge bat_rst_n)
    begin
        if (!bat_rst_n)
        begin
            raw <= hbc_pkg::IRQ_RESET;
        end
        else
        begin
            raw <= (raw & ~clr) | evt;
        end
    end

    assign masked = raw & irq_en;

    always_ff @(posedge clk or negedge bat_rst_n)
    begin
        if (!bat_rst_n)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= ctrl.unit_enable && (|masked);
        end
    end

    // ======================================================================
    // Pin retention
    always_ff @(posedge clk or negedge bat_rst_n)
    begin
        if (!bat_rst_n)
        begin
            hold_active <= 1'b0;
            gpio_unit_rst <= 1'b0;
        end
        else
        begin
            gpio_unit_rst <= hib_req;
            if (!ctrl.retention_enable || !ctrl.unit_enable)
            begin
                hold_active <= 1'b0;
            end
            else if (hib_req)
            begin
                hold_active <= 1'b1;
            end
        end
    end

    hbc_pin_hold #(
        .PINS(PINS)
    ) u_pin_hold (
        .clk(clk),
        .bat_rst_n(bat_rst_n),
        .hold(hold_active),
        .gpio_out(gpio_out),
        .pad_out(pad_out)
    );

    // ======================================================================
    // Read decode and read channel
    always_comb
    begin
        next_rdata = '0;
        next_rhit = 1'b1;
        if (s_axi_araddr[7:2] == hbc_pkg::OFS_CTRL[7:2])
        begin
            next_rdata[hbc_pkg::CTRL_W-1:0] = ctrl;
            next_rdata[hbc_pkg::CTRL_BUSY_BIT] = busy;
        end
        else if (s_axi_araddr[7:2] == hbc_pkg::OFS_RATE[7:2])
        begin
            next_rdata = {rate_byte[3], rate_byte[2], rate_byte[1], rate_byte[0]};
        end
        else if (s_axi_araddr[7:2] == hbc_pkg::OFS_IRQ_EN[7:2])
        begin
            next_rdata[hbc_pkg::IRQ_N-1:0] = irq_en;
        end
        else if (s_axi_araddr[7:2] == hbc_pkg::OFS_IRQ_STATUS[7:2])
        begin
            next_rdata[hbc_pkg::IRQ_N-1:0] = ctrl.status_view_select ? masked : raw;
        end
        else if (s_axi_araddr[7:2] != hbc_pkg::OFS_IRQ_CLEAR[7:2])
        begin
            next_rhit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= hbc_pkg::RESP_OKAY;
            rd_ctrl_q <= 1'b0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rhit ? hbc_pkg::RESP_OKAY : hbc_pkg::RESP_SLVERR;
            rd_ctrl_q <= (s_axi_araddr[7:2] == hbc_pkg::OFS_CTRL[7:2]);
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ======================================================================
    // Checks
    logic [hbc_pkg::IRQ_N-1:0] pend_keep;
    logic [hbc_pkg::IRQ_N-1:0] clr_only;
    logic [hbc_pkg::IRQ_N-1:0] set_clr;
    logic irq_cause;
    logic ret_bit;

    assign pend_keep = raw & ~clr;
    assign clr_only = clr & ~evt;
    assign set_clr = evt & clr;
    assign irq_cause = ctrl.unit_enable && (|masked);
    assign ret_bit = ctrl.retention_enable;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n || !bat_rst_n);

    sequence s_release;
        !hold_active ##1 (pad_out == $past(gpio_out));
    endsequence

    sequence s_stall_wait;
        (!s_axi_bvalid && busy) [*4] ##1 s_axi_bvalid;
    endsequence

    AST_OFF_QUIET: assert property (!ctrl.unit_enable |=> !irq && !hold_active)
        else $error("disabled unit still signals");
    AST_HOLD_STEADY: assert property (hold_active |=> $stable(pad_out))
        else $error("held pin changed");
    AST_GPIO_RST: assert property (hib_req |=> gpio_unit_rst)
        else $error("gpio unit not reset in hibernation");
    AST_RELEASE: assert property (!ctrl.retention_enable |=> s_release)
        else $error("pins not returned to gpio unit");
    AST_RET_READ: assert property ($rose(s_axi_rvalid) && rd_ctrl_q
        |-> s_axi_rdata[hbc_pkg::CTRL_RETENTION_BIT] == $past(ret_bit))
        else $error("retention readback wrong");
    AST_WRC: assert property (wr_done && ctrl.unit_enable |=> raw[hbc_pkg::WR_COMPLETE_IRQ])
        else $error("write complete not flagged");
    AST_PENDING: assert property ((|pend_keep) |=> ($past(pend_keep) & ~raw) == '0)
        else $error("pending source lost without clear");
    AST_CLEAR: assert property ((|clr_only) |=> (raw & $past(clr_only)) == '0)
        else $error("clear did not take");
    AST_SET_WINS: assert property ((|set_clr) |=> (raw & $past(set_clr)) == $past(set_clr))
        else $error("set lost to clear");
    AST_IRQ: assert property (irq_cause |=> irq)
        else $error("masked source not signalled");
    AST_BATLOW: assert property (battery_low && ctrl.battery_low_detect_enable
        && ctrl.unit_enable |=> raw[hbc_pkg::BATTERY_LOW_IRQ])
        else $error("low battery not flagged");
    AST_STALL: assert property (wr_fire && ctrl.write_bus_stall_enable |=> s_stall_wait)
        else $error("stalled write response timing wrong");

endmodule

/* File: verification/hbc_gpio_model.sv */
// =====
// GPIO unit model: reset drops its setup, undriven pins wander
module hbc_gpio_model (
    input wire logic clk,
    input wire logic unit_rst,
    input wire logic cfg_we,
    input wire logic [7:0] cfg_val,
    output logic [7:0] gpio_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cfg_ok;
    logic [7:0] cfg;

    always_ff @(posedge clk)
    begin
        if (unit_rst)
        begin
            cfg_ok <= 1'b0;
        end
        else if (cfg_we)
        begin
            cfg_ok <= 1'b1;
            cfg <= cfg_val;
        end
        gpio_out <= cfg_ok ? cfg : ~gpio_out;
    end
endmodule

/* File: verification/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic vbat_rst_b = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [6:0] ev = 7'h00;
    logic hib_req = 1'b0;
    logic cfg_we = 1'b0;
    logic [7:0] cfg_val = 8'h00;
    logic awready, wready, bvalid, arready, rvalid, irq, gpio_rst;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata;
    logic [7:0] gpio_out, pad_out;
    int n_fail = 0;
    int n_compared = 0;
    int lat;

    always #5 clk = ~clk;

    hbc_ctrl hbc_ctrl_i (
        .clk(clk), .rst_b(rst_b), .vbat_rst_b(vbat_rst_b),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wake_pin_evt(ev[1]), .battery_low(ev[2]), .counter_match_evt(ev[3]),
        .supply_fail(ev[4]), .reset_wake_evt(ev[5]), .gpio_wake_evt(ev[6]),
        .hib_req(hib_req), .gpio_out(gpio_out), .pad_out(pad_out),
        .gpio_unit_rst(gpio_rst), .irq(irq)
    );

    hbc_gpio_model hbc_gpio_model_i (
        .clk(clk), .unit_rst(gpio_rst), .cfg_we(cfg_we), .cfg_val(cfg_val),
        .gpio_out(gpio_out)
    );

    // =====
    // Bus and compare tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        lat = -1;
        do
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            lat++;
        end
        while (!(bvalid && bready));
        bready <= 1'b0;
        resp = bresp;
        repeat (6) @(posedge clk);
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (!(rvalid && rready));
        rready <= 1'b0;
        resp = rresp;
        chk(what, exp, rdata);
    endtask

    task automatic pulse(input logic [6:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 7'h00;
        repeat (2) @(posedge clk);
    endtask

    task automatic final_report();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report();
    end

    // =====
    // Tests
    initial
    begin
        int i;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        vbat_rst_b <= 1'b1;
        cfg_we <= 1'b1;
        cfg_val <= 8'hA5;
        repeat (4) @(posedge clk);
        cfg_we <= 1'b0;
        rdc("ctrl cold", hbc_pkg::OFS_CTRL, 32'h0000_0000);
        pulse(7'h02);
        rdc("raw disabled", hbc_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
        chk("irq disabled", 32'h0000_0000, {31'h0, irq});
        rdc("bad rdata", 8'h14, 32'h0000_0000);
        chk("bad rresp", {30'h0, hbc_pkg::RESP_SLVERR}, {30'h0, resp});
        wr(8'h14, 32'h0000_0001);
        chk("bad bresp", {30'h0, hbc_pkg::RESP_SLVERR}, {30'h0, resp});
        wr(hbc_pkg::OFS_CTRL, 32'h0000_0009);
        wr(hbc_pkg::OFS_RATE, 32'h05F5_E100);
        rdc("rate", hbc_pkg::OFS_RATE, 32'h05F5_E100);
        rdc("raw wc", hbc_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
        for (i = 1; i < 7; i++)
        begin
            pulse(7'h01 << i);
            rdc("raw set", hbc_pkg::OFS_IRQ_STATUS, (32'h1 << i) | 32'h1);
            wr(hbc_pkg::OFS_IRQ_CLEAR, 32'h1 << i);
            rdc("raw clr", hbc_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
        end
        pulse(7'h7E);
        rdc("raw all", hbc_pkg::OFS_IRQ_STATUS, 32'h0000_007F);
        wr(hbc_pkg::OFS_IRQ_CLEAR, 32'h0000_0000);
        rdc("clr none", hbc_pkg::OFS_IRQ_STATUS, 32'h0000_007F);
        wr(hbc_pkg::OFS_IRQ_CLEAR, 32'h0000_0014);
        rdc("clr some", hbc_pkg::OFS_IRQ_STATUS, 32'h0000_006B);
        wr(hbc_pkg::OFS_IRQ_EN, 32'h0000_0008);
        chk("irq on", 32'h0000_0001, {31'h0, irq});
        wr(hbc_pkg::OFS_CTRL, 32'h0000_0019);
        rdc("masked", hbc_pkg::OFS_IRQ_STATUS, 32'h0000_0008);
        wr(hbc_pkg::OFS_IRQ_EN, 32'h0000_0004);
        rdc("masked off", hbc_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
        chk("irq off", 32'h0000_0000, {31'h0, irq});
        pulse(7'h04);
        repeat (8) @(posedge clk);
        chk("irq held", 32'h0000_0001, {31'h0, irq});
        rdc("masked bat", hbc_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
        ev <= 7'h04;
        wr(hbc_pkg::OFS_IRQ_CLEAR, 32'h0000_0004);
        ev <= 7'h00;
        rdc("set wins", hbc_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
        wr(hbc_pkg::OFS_IRQ_CLEAR, 32'h0000_0004);
        chk("irq clr", 32'h0000_0000, {31'h0, irq});
        wr(hbc_pkg::OFS_CTRL, 32'h0000_0001);
        rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        rdc("active", hbc_pkg::OFS_CTRL, 32'h0000_0001);
        rdc("wake cause", hbc_pkg::OFS_IRQ_STATUS, 32'h0000_006B);
        wr(hbc_pkg::OFS_CTRL, 32'h0000_0003);
        rdc("retain on", hbc_pkg::OFS_CTRL, 32'h0000_0003);
        hib_req <= 1'b1;
        repeat (4) @(posedge clk);
        chk("gpio rst", 32'h0000_0001, {31'h0, gpio_rst});
        chk("pad hib", 32'h0000_00A5, {24'h0, pad_out});
        hib_req <= 1'b0;
        repeat (4) @(posedge clk);
        cfg_we <= 1'b1;
        cfg_val <= 8'h3C;
        @(posedge clk);
        cfg_we <= 1'b0;
        repeat (3) @(posedge clk);
        chk("pad wake", 32'h0000_00A5, {24'h0, pad_out});
        wr(hbc_pkg::OFS_CTRL, 32'h0000_0001);
        chk("latency", 32'h0000_0002, lat);
        chk("pad back", 32'h0000_003C, {24'h0, pad_out});
        rdc("retain off", hbc_pkg::OFS_CTRL, 32'h0000_0001);
        wr(hbc_pkg::OFS_CTRL, 32'h0000_0005);
        wr(hbc_pkg::OFS_RATE, 32'h0000_0000);
        chk("stall latency", 32'h0000_0006, lat);
        final_report();
    end
endmodule
